// ==== verilog/pmcc_pkg.sv ====
package pmcc_pkg;
  localparam logic [3:0] PMCC_ADDR_PWR_CTRL = 4'h0;
  localparam logic [3:0] PMCC_ADDR_HF_OSC   = 4'h1;
  localparam logic [3:0] PMCC_ADDR_REG_CTRL = 4'h2;
  localparam logic [3:0] PMCC_ADDR_CLK_SEL  = 4'h3;
  localparam logic [3:0] PMCC_ADDR_CLK_GATE = 4'h4;
  localparam logic [3:0] PMCC_ADDR_STATUS   = 4'h5;
  localparam int PMCC_BIT_IDLE    = 0;
  localparam int PMCC_BIT_STOP    = 1;
  localparam int PMCC_BIT_SUSPEND = 0;
  localparam int PMCC_BIT_STOPCFG = 0;
  localparam int PMCC_BIT_REG5V   = 1;
  localparam int PMCC_SRC_LSB     = 0;
  localparam int PMCC_DIV_LSB     = 2;
  localparam int PMCC_PRE_LSB     = 4;
  localparam logic [1:0] PMCC_SRC_HF  = 2'h0;
  localparam logic [1:0] PMCC_SRC_LF  = 2'h1;
  localparam logic [1:0] PMCC_SRC_EXT = 2'h2;
  localparam logic [1:0] PMCC_DIV_RST = 2'h3;
  localparam logic [1:0] PMCC_PRE_RST = 2'h2;
  localparam logic [7:0] PMCC_GATE_RST = 8'h00;
  localparam int PMCC_HF_KHZ = 48000;
  localparam int PMCC_LF_KHZ = 80;
  typedef enum logic [2:0] {PM_NORMAL, PM_IDLE, PM_SUSPEND, PM_STOP, PM_SHUTDOWN} pmcc_mode_t;
endpackage

// ==== verilog/pmcc_div_if.sv ====
`timescale 1ns/10ps
interface pmcc_div_if;
  logic       clk_en;
  logic [1:0] src;
  logic [1:0] pre;
  logic [1:0] div;
  logic       tick;
  modport ctrl (output clk_en, output src, output pre, output div, input tick);
  modport div_m (input clk_en, input src, input pre, input div, output tick);
endinterface

// ==== verilog/pmcc_clk_div.sv ====
`timescale 1ns/10ps
module pmcc_clk_div
  import pmcc_pkg::*;
(
  input  wire logic sys_clk_i,
  input  wire logic nrst_i,
  input  wire logic ce_i,
  input  wire logic hf_tick_i,
  input  wire logic lf_tick_i,
  input  wire logic ext_tick_i,
  pmcc_div_if.div_m d
);
  logic [5:0] cnt_q;
  logic       src_tick;
  logic [6:0] lim;

  // Total division is the prescale power times the divider power, up to 64.
  function automatic logic [6:0] pow2(input logic [2:0] e);
    pow2 = 7'(1 << e);
  endfunction

  always_comb
  begin
    case (d.src)
      PMCC_SRC_HF:  src_tick = hf_tick_i;
      PMCC_SRC_LF:  src_tick = lf_tick_i;
      PMCC_SRC_EXT: src_tick = ext_tick_i;
      default:      src_tick = hf_tick_i;
    endcase
    lim = pow2({1'b0, d.pre} + {1'b0, d.div});
  end

  always_ff @(posedge sys_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
      cnt_q <= 6'h00;
    else if (ce_i && d.clk_en && src_tick)
    begin
      if ({1'b0, cnt_q} >= lim - 7'h01)
        cnt_q <= 6'h00;
      else
        cnt_q <= cnt_q + 6'h01;
    end
  end

  assign d.tick = ce_i && d.clk_en && src_tick && ({1'b0, cnt_q} >= lim - 7'h01);
endmodule

// ==== verilog/pmcc_top.sv ====
// Behaviour
// - Idle halts core, peripherals run, interrupt wakes.
// - Suspend from HF source stops clocks, USB wakes.
// - Stop cuts power nets; any reset exits.
// - Shutdown needs config bit, then stop bit.
// - Shutdown exits only on pin or power-on reset.
// - Reset clock is HF divided 4 then 8.
// - Divider selects 1, 2, 4 or 8.
// - Source is HF, LF or external clock.
// - Unused digital peripherals get clocks gated.
//
// Local design decisions: the strobed register port and the address map.
`timescale 1ns/10ps
module pmcc_top
  import pmcc_pkg::*;
(
  input  wire logic       sys_clk_i,
  input  wire logic       nrst_i,
  input  wire logic       ce_i,
  input  wire logic [3:0] addr_i,
  input  wire logic [7:0] wdata_i,
  input  wire logic       wr_i,
  input  wire logic       rd_i,
  output logic      [7:0] rdata_o,
  input  wire logic       irq_any_i,
  input  wire logic       usb_activity_i,
  input  wire logic       reset_pin_n_i,
  input  wire logic       por_i,
  input  wire logic       other_reset_i,
  input  wire logic       hf_tick_i,
  input  wire logic       lf_tick_i,
  input  wire logic       ext_tick_i,
  input  wire logic [7:0] periph_busy_i,
  output logic            core_clk_en_o,
  output logic            periph_clk_en_o,
  output logic      [7:0] periph_gate_en_o,
  output logic            system_clock_tick_o,
  output logic            power_nets_on_o,
  output logic            pin_hold_o,
  output logic            reg5v_on_o,
  output logic      [2:0] mode_o
);
  pmcc_mode_t mode_q;
  logic       idle_q;
  logic       stop_q;
  logic       suspend_q;
  logic       stopcfg_q;
  logic       reg5v_q;
  logic [1:0] src_q;
  logic [1:0] div_q;
  logic [1:0] pre_q;
  logic [7:0] gate_q;
  logic [7:0] rdata_q;
  logic       wr_pc;
  logic       wr_hf;
  logic       any_reset;
  logic       deep_reset;
  pmcc_div_if dif ();

  assign wr_pc      = wr_i && addr_i == PMCC_ADDR_PWR_CTRL;
  assign wr_hf      = wr_i && addr_i == PMCC_ADDR_HF_OSC;
  assign any_reset  = !reset_pin_n_i || por_i || other_reset_i;
  assign deep_reset = !reset_pin_n_i || por_i;

  // Mode sequencing; low-power requests are taken only from normal mode.
  always_ff @(posedge sys_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
      mode_q <= PM_NORMAL;
    else if (ce_i)
    begin
      case (mode_q)
        PM_NORMAL:
        begin
          if (wr_pc && wdata_i[PMCC_BIT_STOP])
            mode_q <= stopcfg_q ? PM_SHUTDOWN : PM_STOP;
          else if (wr_pc && wdata_i[PMCC_BIT_IDLE])
            mode_q <= PM_IDLE;
          else if (wr_hf && wdata_i[PMCC_BIT_SUSPEND] && src_q == PMCC_SRC_HF)
            mode_q <= PM_SUSPEND;
        end
        PM_IDLE:
          if (irq_any_i)
            mode_q <= PM_NORMAL;
        PM_SUSPEND:
          if (usb_activity_i)
            mode_q <= PM_NORMAL;
        PM_STOP:
          if (any_reset)
            mode_q <= PM_NORMAL;
        PM_SHUTDOWN:
          if (deep_reset)
            mode_q <= PM_NORMAL;
        default:
          mode_q <= PM_NORMAL;
      endcase
    end
  end

  // Request bits reflect the pending mode and drop on wake.
  always_ff @(posedge sys_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      idle_q    <= 1'b0;
      stop_q    <= 1'b0;
      suspend_q <= 1'b0;
    end
    else if (ce_i)
    begin
      if (mode_q == PM_NORMAL)
      begin
        if (wr_pc && wdata_i[PMCC_BIT_STOP])
          stop_q <= 1'b1;
        else if (wr_pc && wdata_i[PMCC_BIT_IDLE])
          idle_q <= 1'b1;
        else if (wr_hf && wdata_i[PMCC_BIT_SUSPEND] && src_q == PMCC_SRC_HF)
          suspend_q <= 1'b1;
      end
      else if ((mode_q == PM_IDLE && irq_any_i)
               || (mode_q == PM_SUSPEND && usb_activity_i)
               || (mode_q == PM_STOP && any_reset)
               || (mode_q == PM_SHUTDOWN && deep_reset))
      begin
        idle_q    <= 1'b0;
        stop_q    <= 1'b0;
        suspend_q <= 1'b0;
      end
    end
  end

  // Configuration registers; writes only land while the core runs.
  always_ff @(posedge sys_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      stopcfg_q <= 1'b0;
      reg5v_q   <= 1'b1;
      src_q     <= PMCC_SRC_HF;
      div_q     <= PMCC_DIV_RST;
      pre_q     <= PMCC_PRE_RST;
      gate_q    <= PMCC_GATE_RST;
    end
    else if (ce_i && wr_i && mode_q == PM_NORMAL)
    begin
      case (addr_i)
        PMCC_ADDR_REG_CTRL:
        begin
          stopcfg_q <= wdata_i[PMCC_BIT_STOPCFG];
          reg5v_q   <= wdata_i[PMCC_BIT_REG5V];
        end
        PMCC_ADDR_CLK_SEL:
        begin
          if (wdata_i[PMCC_SRC_LSB +: 2] != 2'h3)
            src_q <= wdata_i[PMCC_SRC_LSB +: 2];
          div_q <= wdata_i[PMCC_DIV_LSB +: 2];
          pre_q <= wdata_i[PMCC_PRE_LSB +: 2];
        end
        PMCC_ADDR_CLK_GATE:
          gate_q <= wdata_i;
        default:
          gate_q <= gate_q;
      endcase
    end
  end

  // Read data stand for the cycle after the strobe only.
  always_ff @(posedge sys_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
      rdata_q <= 8'h00;
    else if (ce_i)
    begin
      if (rd_i)
      begin
        case (addr_i)
          PMCC_ADDR_PWR_CTRL: rdata_q <= {6'h00, stop_q, idle_q};
          PMCC_ADDR_HF_OSC:   rdata_q <= {7'h00, suspend_q};
          PMCC_ADDR_REG_CTRL: rdata_q <= {6'h00, reg5v_q, stopcfg_q};
          PMCC_ADDR_CLK_SEL:  rdata_q <= {2'h0, pre_q, div_q, src_q};
          PMCC_ADDR_CLK_GATE: rdata_q <= gate_q;
          PMCC_ADDR_STATUS:   rdata_q <= {5'h00, mode_q};
          default:            rdata_q <= 8'h00;
        endcase
      end
      else
        rdata_q <= 8'h00;
    end
  end

  assign rdata_o          = rdata_q;
  assign core_clk_en_o    = mode_q == PM_NORMAL;
  assign periph_clk_en_o  = mode_q == PM_NORMAL || mode_q == PM_IDLE;
  // A peripheral is clocked only while enabled, busy and its clocks are not halted.
  assign periph_gate_en_o = periph_clk_en_o ? (gate_q & periph_busy_i) : 8'h00;
  assign power_nets_on_o  = mode_q != PM_STOP && mode_q != PM_SHUTDOWN;
  assign pin_hold_o       = !power_nets_on_o;
  assign reg5v_on_o       = reg5v_q && (mode_q != PM_SHUTDOWN || reg5v_q);
  assign mode_o           = mode_q;

  assign dif.clk_en = periph_clk_en_o;
  assign dif.src    = src_q;
  assign dif.pre    = pre_q;
  assign dif.div    = div_q;
  assign system_clock_tick_o = dif.tick;

  pmcc_clk_div u_div (
    .sys_clk_i  (sys_clk_i),
    .nrst_i     (nrst_i),
    .ce_i       (ce_i),
    .hf_tick_i  (hf_tick_i),
    .lf_tick_i  (lf_tick_i),
    .ext_tick_i (ext_tick_i),
    .d          (dif)
  );
endmodule

// ==== tb/pmcc_top_monitor.sv ====
`timescale 1ns/10ps
module pmcc_top_monitor (
  input wire logic       sys_clk_i,
  input wire logic       nrst_i,
  input wire logic       ce_i,
  input wire logic       irq_any_i,
  input wire logic       usb_activity_i,
  input wire logic       reset_pin_n_i,
  input wire logic       por_i,
  input wire logic       other_reset_i,
  input wire logic [7:0] periph_busy_i,
  input wire logic       core_clk_en_o,
  input wire logic       periph_clk_en_o,
  input wire logic [7:0] periph_gate_en_o,
  input wire logic       power_nets_on_o,
  input wire logic       pin_hold_o,
  input wire logic [2:0] mode_o
);
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!nrst_i);
  property p_clk;
    core_clk_en_o == (mode_o == 3'h0) && periph_clk_en_o == (mode_o < 3'h2);
  endproperty
  a_clk: assert property (p_clk) else $error("clock enables wrong");
  property p_pwr;
    power_nets_on_o == (mode_o < 3'h3) && pin_hold_o == !power_nets_on_o;
  endproperty
  a_pwr: assert property (p_pwr) else $error("power nets wrong");
  property p_gate;
    (periph_gate_en_o & ~periph_busy_i) == 8'h00 && (periph_clk_en_o || !periph_gate_en_o);
  endproperty
  a_gate: assert property (p_gate) else $error("gate on while unused");
  property p_wake;
    ce_i && mode_o == 3'h1 && irq_any_i |=> mode_o == 3'h0;
  endproperty
  a_wake: assert property (p_wake) else $error("idle not woken");
  property p_usb;
    ce_i && mode_o == 3'h2 && usb_activity_i |=> mode_o == 3'h0;
  endproperty
  a_usb: assert property (p_usb) else $error("suspend not woken");
  property p_stop;
    ce_i && mode_o == 3'h3 && (por_i || !reset_pin_n_i || other_reset_i) |=> mode_o == 3'h0;
  endproperty
  a_stop: assert property (p_stop) else $error("stop not left");
  property p_stay;
    mode_o == 3'h3 && !por_i && reset_pin_n_i && !other_reset_i |=> mode_o == 3'h3;
  endproperty
  a_stay: assert property (p_stay) else $error("stop left early");
  property p_shut;
    mode_o == 3'h4 && reset_pin_n_i && !por_i |=> mode_o == 3'h4;
  endproperty
  a_shut: assert property (p_shut) else $error("shutdown left early");
endmodule

bind pmcc_top pmcc_top_monitor u_mon (.sys_clk_i, .nrst_i, .ce_i, .irq_any_i, .usb_activity_i,
  .reset_pin_n_i, .por_i, .other_reset_i, .periph_busy_i, .core_clk_en_o, .periph_clk_en_o,
  .periph_gate_en_o, .power_nets_on_o, .pin_hold_o, .mode_o);

// ==== tb/test_power_mode_clock_control.sv ====
`timescale 1ns/10ps
module test_power_mode_clock_control;
  logic       sys_clk_i, nrst_i, ce_i, wr_i, rd_i, hf_tick_i, lf_tick_i, ext_tick_i;
  logic       core_clk_en_o, periph_clk_en_o, system_clock_tick_o, power_nets_on_o, pin_hold_o;
  logic       reg5v_on_o;
  logic [2:0] mode_o;
  logic [3:0] en;
  logic [3:0] addr_i;
  logic [4:0] wk;
  logic [7:0] wdata_i, periph_busy_i, rdata_o, periph_gate_en_o, g;
  int         err_total, cmp_count, cyc, m, sh, src, n;
  pmcc_top u_dut (.sys_clk_i, .nrst_i, .ce_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o,
    .irq_any_i(wk[0]), .usb_activity_i(wk[1]), .reset_pin_n_i(!wk[2]), .por_i(wk[3]),
    .other_reset_i(wk[4]), .hf_tick_i, .lf_tick_i, .ext_tick_i, .periph_busy_i,
    .core_clk_en_o, .periph_clk_en_o, .periph_gate_en_o, .system_clock_tick_o,
    .power_nets_on_o, .pin_hold_o, .reg5v_on_o, .mode_o);
  assign en = {core_clk_en_o, periph_clk_en_o, power_nets_on_o, pin_hold_o};
  initial
  begin
    sys_clk_i = 1'b0;
    forever #25 sys_clk_i = ~sys_clk_i;
  end
  // Low source ticks every second cycle, external every fourth.
  always @(posedge sys_clk_i)
  begin
    cyc <= cyc + 1;
    lf_tick_i <= cyc[0];
    ext_tick_i <= cyc[1:0] == 2'h0;
    if (cyc == 20000)
    begin
      err_total++;
      give_verdict;
    end
  end
  task give_verdict;
    $display("checks %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task chk(input string s, input logic [7:0] e, input logic [7:0] v);
    cmp_count++;
    if (v !== e)
    begin
      err_total++;
      $display("ERROR %s expected %h seen %h", s, e, v);
    end
  endtask
  task chk_mode;
    chk("mode", 8'(m), {5'h0, mode_o});
    chk("enables", {4'h0, m == 0, m < 2, m < 3, m > 2}, {4'h0, en});
  endtask
  task wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge sys_clk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge sys_clk_i);
    wr_i <= 1'b0;
    if (m == 0 && a == 4'h0 && d[1])
      m = sh ? 4 : 3;
    else if (m == 0 && a == 4'h0 && d[0])
      m = 1;
    if (m == 0 && a == 4'h1 && d[0] && src == 0)
      m = 2;
    if (m == 0 && a == 4'h2)
      sh = d[0];
    if (m == 0 && a == 4'h3 && d[1:0] != 2'h3)
      src = d[1:0];
    @(negedge sys_clk_i);
    chk_mode;
  endtask
  task ev(input int k);
    @(posedge sys_clk_i);
    wk[k] <= 1'b1;
    @(posedge sys_clk_i);
    wk[k] <= 1'b0;
    if ((k == 0 && m == 1) || (k == 1 && m == 2) || (k > 1 && m == 3) || (k > 1 && k < 4 && m == 4))
      m = 0;
    @(negedge sys_clk_i);
    chk_mode;
  endtask
  task rd(input logic [3:0] a, input logic [7:0] e);
    @(posedge sys_clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge sys_clk_i);
    rd_i <= 1'b0;
    @(negedge sys_clk_i);
    chk("rdata", e, rdata_o);
  endtask
  task tk(input int c, input int e);
    n = 0;
    repeat (c) @(negedge sys_clk_i);
    repeat (c)
    begin
      @(negedge sys_clk_i);
      if (system_clock_tick_o === 1'b1)
        n++;
    end
    chk("ticks", 8'(e), 8'(n));
  endtask
  initial
  begin
    nrst_i = 1'b0;
    ce_i = 1'b1;
    {wr_i, rd_i, addr_i, wdata_i, periph_busy_i, wk} = '0;
    hf_tick_i = 1'b1;
    void'($urandom(32'heb2c));
    repeat (16) @(posedge sys_clk_i);
    nrst_i <= 1'b1;
    tk(320, 10);
    rd(4'h2, 8'h02);
    rd(4'h3, 8'h2c);
    rd(4'hf, 8'h00);
    $display("reset test done");
    for (int i = 0; i < 4; i++)
    begin
      wr(4'h3, 8'(i << 2));
      tk(64, 64 >> i);
    end
    for (int i = 1; i < 4; i++)
    begin
      wr(4'h3, 8'(i));
      tk(64, i == 1 ? 32 : 16);
    end
    @(posedge sys_clk_i) ce_i <= 1'b0;
    tk(8, 0);
    @(posedge sys_clk_i) ce_i <= 1'b1;
    $display("clock test done");
    repeat (4)
    begin
      g = 8'($urandom);
      @(posedge sys_clk_i) periph_busy_i <= 8'($urandom);
      wr(4'h4, g);
      chk("gate", g & periph_busy_i, periph_gate_en_o);
    end
    wr(4'h3, 8'h01);
    wr(4'h1, 8'h01);
    wr(4'h3, 8'h00);
    wr(4'h1, 8'h01);
    ev(0);
    ev(1);
    wr(4'h0, 8'h01);
    ev(1);
    ev(0);
    rd(4'h0, 8'h00);
    wr(4'h0, 8'h03);
    ev(0);
    ev(4);
    $display("mode test done");
    for (int k = 2; k < 4; k++)
    begin
      wr(4'h2, k == 2 ? 8'h03 : 8'h01);
      wr(4'h0, 8'h02);
      chk("reg5v", {7'h0, k == 2}, {7'h0, reg5v_on_o});
      ev(0);
      ev(4);
      ev(k);
    end
    $display("shutdown test done");
    give_verdict;
  end
endmodule
